// ==== logic/firc_deb_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface firc_deb_if #(
	parameter int N = 4
);
	logic             tick;
	logic [N-1:0]     raw;
	logic [N*16-1:0]  times;
	logic [N-1:0]     level;

	modport ctrl (
		output tick,
		output raw,
		output times,
		input  level
	);
	modport deb (
		input  tick,
		input  raw,
		input  times,
		output level
	);
endinterface : firc_deb_if
`default_nettype wire

// ==== logic/firc_debounce.sv ====
`timescale 1ns/1ps
`default_nettype none
module firc_debounce #(
	parameter int N = 4
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	firc_deb_if.deb   dif
);
	generate
		for (genvar i = 0; i < N; i++) begin : g_ch
			logic [15:0] count;
			logic        level;
			wire  [15:0] time_ms  = dif.times[i*16 +: 16];
			wire         differs  = dif.raw[i] != level;
			wire  [15:0] count_up = count + 16'h0001;
			wire         expired  = differs && dif.tick && (count_up >= time_ms);
			wire  [15:0] next_count = !differs ? 16'h0000 :
				expired ? 16'h0000 : dif.tick ? count_up : count;

			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					count <= 16'h0000;
					level <= 1'b0;
				end else begin
					count <= next_count;
					if (expired) begin
						level <= dif.raw[i];
					end
				end
			end
			assign dif.level[i] = level;
		end
	endgenerate
endmodule : firc_debounce
`default_nettype wire

// ==== logic/firc_pkg.sv ====
// Functional notes
// - power-down applies off, on, keep or toggle
// - power-down action resets to off
// - two-wire: run follows run input
// - three-wire: no run without permissive
// - three-wire: permissive drop stops motor
// - three-wire: held or pulsed run starts
// - four 16-bit debounce times, 5..5000 ms
// - debounce applies to both edges
// - wiring mode resets to two-wire
`default_nettype none
package firc_pkg;
	localparam logic [15:0] OFS_PWRDN_ACTION = 16'h02D6;
	localparam logic [15:0] OFS_WIRING_MODE  = 16'h02D8;
	localparam logic [15:0] OFS_DEB_TIME0    = 16'h02D9;
	localparam logic [15:0] OFS_STATUS       = 16'h02E0;
	localparam int          NUM_INPUTS       = 4;
	localparam int          RUN_INPUT        = 0;
	localparam int          PERMIT_INPUT     = 1;
	localparam logic [1:0]  RST_PWRDN_ACTION = 2'h0;
	localparam logic [0:0]  RST_WIRING_MODE  = 1'h0;
	localparam logic [15:0] RST_DEB_TIME     = 16'h0014;
	localparam logic [15:0] DEB_TIME_MIN     = 16'h0005;
	localparam logic [15:0] DEB_TIME_MAX     = 16'h1388;
	localparam int          CLK_PERIOD_NS    = 10;
	localparam int          MS_NS            = 1000000;
	localparam int          TICK_CYC         = MS_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		PD_OFF,
		PD_ON,
		PD_KEEP,
		PD_TOGGLE
	} firc_pd_action_t;

	typedef enum logic [0:0] {
		WIRE_TWO,
		WIRE_THREE
	} firc_wiring_t;
endpackage : firc_pkg
`default_nettype wire

// ==== logic/firc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module firc_top #(
	parameter int TICK_CYC = firc_pkg::TICK_CYC,
	parameter int N_IN     = firc_pkg::NUM_INPUTS
) (
	input  wire logic            SYS_CLK_I,
	input  wire logic            RESET_I,
	input  wire logic [N_IN-1:0] FIELD_IN_I,
	input  wire logic            POWER_LOSS_I,
	input  wire logic            RELAY_CMD_I,
	input  wire logic [15:0]     REG_ADDR_I,
	input  wire logic            REG_WR_I,
	input  wire logic            REG_RD_I,
	input  wire logic [15:0]     REG_WDATA_I,
	output logic      [15:0]     REG_RDATA_O,
	output logic                 REG_ACK_O,
	output logic                 REG_ERR_O,
	output logic                 MOTOR_RUN_O,
	output logic                 RELAY_O,
	output logic      [N_IN-1:0] DEB_IN_O
);
	localparam int TW = $clog2(TICK_CYC + 1);

	generate
		if (TICK_CYC < 1 || N_IN < 2 || N_IN > 8) begin : g_bad
			$error("firc_top: unsupported TICK_CYC or N_IN");
		end
	endgenerate

	firc_deb_if #(.N(N_IN)) dif ();

	// three-stage input synchronisers
	logic [N_IN:0] sync1;
	logic [N_IN:0] sync2;
	logic [N_IN:0] sync3;
	logic [N_IN:0] filt;
	wire  [N_IN:0] pins = {POWER_LOSS_I, FIELD_IN_I};
	wire  [N_IN:0] agree = ~(sync2 ^ sync3);
	wire  [N_IN:0] next_filt = (agree & sync3) | (~agree & filt);

	always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
			filt  <= '0;
		end else begin
			sync1 <= pins;
			sync2 <= sync1;
			sync3 <= sync2;
			filt  <= next_filt;
		end
	end

	// millisecond tick
	logic [TW-1:0] tick_cnt;
	logic          tick;
	wire           tick_wrap = (tick_cnt == TW'(TICK_CYC - 1));
	wire [TW-1:0]  next_tick_cnt = tick_wrap ? '0 : tick_cnt + TW'(1);

	always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			tick_cnt <= '0;
			tick     <= 1'b0;
		end else begin
			tick_cnt <= next_tick_cnt;
			tick     <= tick_wrap;
		end
	end

	// register file
	logic [1:0]        pd_action;
	logic [0:0]        wiring;
	logic [15:0]       deb_time [N_IN];

	wire hit_pd     = (REG_ADDR_I == firc_pkg::OFS_PWRDN_ACTION);
	wire hit_wiring = (REG_ADDR_I == firc_pkg::OFS_WIRING_MODE);
	wire hit_status = (REG_ADDR_I == firc_pkg::OFS_STATUS);
	wire [15:0] deb_idx = REG_ADDR_I - firc_pkg::OFS_DEB_TIME0;
	wire hit_deb    = (REG_ADDR_I >= firc_pkg::OFS_DEB_TIME0) && (deb_idx < 16'(N_IN));
	wire mapped     = hit_pd || hit_wiring || hit_status || hit_deb;
	wire deb_in_range = (REG_WDATA_I >= firc_pkg::DEB_TIME_MIN) && (REG_WDATA_I <= firc_pkg::DEB_TIME_MAX);
	wire pd_ok      = (REG_WDATA_I[15:2] == 14'h0000);
	wire wiring_ok  = (REG_WDATA_I[15:1] == 15'h0000);
	wire wr_ok      = (hit_pd && pd_ok) || (hit_wiring && wiring_ok) || (hit_deb && deb_in_range);
	wire wr_pd      = REG_WR_I && hit_pd && pd_ok;
	wire wr_wiring  = REG_WR_I && hit_wiring && wiring_ok;
	wire wr_deb     = REG_WR_I && hit_deb && deb_in_range;

	logic motor_run;
	logic relay;
	logic [15:0] rd_deb;
	always_comb begin
		rd_deb = 16'h0000;
		for (int k = 0; k < N_IN; k++) begin
			if (deb_idx == 16'(k)) begin
				rd_deb = deb_time[k];
			end
		end
	end

	wire [15:0] status_word = {6'h00, relay, motor_run, {(8 - N_IN){1'b0}}, dif.level};
	wire [15:0] rd_mux = hit_pd ? {14'h0000, pd_action} :
		hit_wiring ? {15'h0000, wiring} :
		hit_status ? status_word :
		hit_deb ? rd_deb : 16'h0000;
	wire        access = REG_WR_I || REG_RD_I;
	wire        bad    = (REG_WR_I && !wr_ok) || (REG_RD_I && !mapped);

	always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			pd_action <= firc_pkg::RST_PWRDN_ACTION;
			wiring    <= firc_pkg::RST_WIRING_MODE;
			for (int k = 0; k < N_IN; k++) begin
				deb_time[k] <= firc_pkg::RST_DEB_TIME;
			end
			REG_RDATA_O <= 16'h0000;
			REG_ACK_O   <= 1'b0;
			REG_ERR_O   <= 1'b0;
		end else begin
			if (wr_pd) begin
				pd_action <= REG_WDATA_I[1:0];
			end
			if (wr_wiring) begin
				wiring <= REG_WDATA_I[0:0];
			end
			for (int k = 0; k < N_IN; k++) begin
				if (wr_deb && deb_idx == 16'(k)) begin
					deb_time[k] <= REG_WDATA_I;
				end
			end
			REG_RDATA_O <= REG_RD_I ? rd_mux : 16'h0000;
			REG_ACK_O   <= access && !bad;
			REG_ERR_O   <= access && bad;
		end
	end

	// debouncer hookup
	assign dif.tick = tick;
	assign dif.raw  = filt[N_IN-1:0];
	generate
		for (genvar i = 0; i < N_IN; i++) begin : g_times
			assign dif.times[i*16 +: 16] = deb_time[i];
		end
	endgenerate

	firc_debounce #(.N(N_IN)) u_deb (
		.clk_i (SYS_CLK_I),
		.rst_i (RESET_I),
		.dif   (dif.deb)
	);

	// motor run command
	wire run_in    = dif.level[firc_pkg::RUN_INPUT];
	wire permit_in = dif.level[firc_pkg::PERMIT_INPUT];
	logic next_run;
	always_comb begin
		case (firc_pkg::firc_wiring_t'(wiring))
			firc_pkg::WIRE_TWO: next_run = run_in;
			// latch on run, drop on permissive loss
			firc_pkg::WIRE_THREE: next_run = permit_in && (run_in || motor_run);
			default: next_run = 1'b0;
		endcase
	end

	// power-down relay action
	wire  pwr_loss = filt[N_IN];
	logic pwr_loss_d;
	wire  pwr_edge = pwr_loss && !pwr_loss_d;
	logic next_relay;
	always_comb begin
		next_relay = relay;
		if (pwr_edge) begin
			case (firc_pkg::firc_pd_action_t'(pd_action))
				firc_pkg::PD_OFF:    next_relay = 1'b0;
				firc_pkg::PD_ON:     next_relay = 1'b1;
				firc_pkg::PD_KEEP:   next_relay = relay;
				firc_pkg::PD_TOGGLE: next_relay = !relay;
				default:             next_relay = 1'b0;
			endcase
		end else if (!pwr_loss) begin
			next_relay = RELAY_CMD_I;
		end
	end

	always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			motor_run  <= 1'b0;
			relay      <= 1'b0;
			pwr_loss_d <= 1'b0;
		end else begin
			motor_run  <= next_run;
			relay      <= next_relay;
			pwr_loss_d <= pwr_loss;
		end
	end

	assign MOTOR_RUN_O = motor_run;
	assign RELAY_O     = relay;
	assign DEB_IN_O    = dif.level;
endmodule : firc_top
`default_nettype wire

// ==== testbench/field_input_run_control_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module field_input_run_control_bench;
	localparam int TK = 10;
	logic        SYS_CLK_I = 1'b0, RESET_I = 1'b1, POWER_LOSS_I = 1'b0, RELAY_CMD_I = 1'b0;
	logic        REG_WR_I = 1'b0, REG_RD_I = 1'b0, REG_ACK_O, REG_ERR_O, MOTOR_RUN_O, RELAY_O;
	logic [15:0] REG_ADDR_I = 16'h0000, REG_WDATA_I = 16'h0000, REG_RDATA_O;
	logic [3:0]  FIELD_IN_I, DEB_IN_O, fld = 4'h0;
	logic        bnc = 1'b0;
	int          err_count = 0, num_checks = 0, st = 0, mode_m = 0;
	int          tm[$] = {20, 20, 20, 20};
	always #5 SYS_CLK_I = ~SYS_CLK_I;
	firc_field_model firc_field_model_inst (.run_i(fld[0]), .perm_i(fld[1]), .aux_i(fld[3:2]), .bounce_i(bnc),
		.field_o(FIELD_IN_I));
	firc_top #(.TICK_CYC(TK)) firc_top_inst (.*);
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic end_sim;
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d, input logic e, input logic [15:0] x);
		REG_WR_I = w;
		REG_RD_I = !w;
		REG_ADDR_I = a;
		REG_WDATA_I = d;
		@(negedge SYS_CLK_I);
		REG_WR_I = 1'b0;
		REG_RD_I = 1'b0;
		chk(REG_ERR_O, e);
		chk(REG_ACK_O, !e);
		if (!w)
			chk(REG_RDATA_O, x);
		// idle cycle so the next request never follows a release in one step
		@(negedge SYS_CLK_I);
	endtask : acc
	// change one contact, await filtered level, then check motor against model
	task automatic deb(input int b, input logic v);
		int n;
		n = 0;
		fld[b] = v;
		while (DEB_IN_O[b] !== v && n < (tm[b] + 2) * TK) begin
			@(negedge SYS_CLK_I);
			n++;
		end
		chk(n >= (tm[b] - 1) * TK && n < (tm[b] + 2) * TK, 1'b1);
		if (n >= (tm[b] + 2) * TK)
			end_sim();
		@(negedge SYS_CLK_I);
		st = mode_m ? int'(fld[1] && (fld[0] || st != 0)) : int'(fld[0]);
		chk(MOTOR_RUN_O, st[0]);
	endtask : deb
	initial begin
		int v;
		v = $urandom(32'hC11206DA);
		repeat (3) @(posedge SYS_CLK_I);
		@(negedge SYS_CLK_I);
		RESET_I = 1'b0;
		acc(1'b0, 16'h02D6, 16'h0000, 1'b0, 16'h0000);
		acc(1'b0, 16'h02D8, 16'h0000, 1'b0, 16'h0000);
		acc(1'b0, 16'h0100, 16'h0000, 1'b1, 16'h0000);
		acc(1'b1, 16'h02D8, 16'h0002, 1'b1, 16'h0000);
		acc(1'b1, 16'h02D6, 16'h0004, 1'b1, 16'h0000);
		acc(1'b1, 16'h02E0, 16'h0000, 1'b1, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			acc(1'b0, 16'h02D9 + 16'(i), 16'h0000, 1'b0, 16'(tm[i]));
			acc(1'b1, 16'h02D9 + 16'(i), 16'h0004, 1'b1, 16'h0000);
			acc(1'b1, 16'h02D9 + 16'(i), 16'h1389, 1'b1, 16'h0000);
			acc(1'b1, 16'h02D9 + 16'(i), 16'h1388, 1'b0, 16'h0000);
			tm[i] = (i == 0) ? 5 : 5 + int'($urandom % 10);
			acc(1'b1, 16'h02D9 + 16'(i), 16'(tm[i]), 1'b0, 16'h0000);
			acc(1'b0, 16'h02D9 + 16'(i), 16'h0000, 1'b0, 16'(tm[i]));
			deb(i, 1'b1);
			deb(i, 1'b0);
		end
		// short chatter must never reach the filtered level
		bnc = 1'b1;
		for (int j = 0; j < 10 * TK; j++) begin
			@(negedge SYS_CLK_I);
			if (j == 2 * TK - 1)
				bnc = 1'b0;
			chk(DEB_IN_O[0], 1'b0);
		end
		acc(1'b1, 16'h02D8, 16'h0001, 1'b0, 16'h0000);
		mode_m = 1;
		deb(0, 1'b1);
		deb(0, 1'b0);
		deb(1, 1'b1);
		deb(0, 1'b1);
		acc(1'b0, 16'h02E0, 16'h0000, 1'b0, 16'h0103);
		deb(0, 1'b0);
		deb(1, 1'b0);
		for (int i = 0; i < 4; i++) begin
			RELAY_CMD_I = 1'($urandom);
			acc(1'b1, 16'h02D6, 16'(i), 1'b0, 16'h0000);
			chk(RELAY_O, RELAY_CMD_I);
			st = (i < 2) ? i : int'(RELAY_CMD_I ^ (i == 3));
			POWER_LOSS_I = 1'b1;
			repeat (10) @(negedge SYS_CLK_I);
			RELAY_CMD_I = ~RELAY_CMD_I;
			repeat (3) @(negedge SYS_CLK_I);
			chk(RELAY_O, st[0]);
			POWER_LOSS_I = 1'b0;
			repeat (8) @(negedge SYS_CLK_I);
		end
		// second reset must restore power-down action, wiring mode and the debounce time of input 3
		RESET_I = 1'b1;
		repeat (3) @(negedge SYS_CLK_I);
		RESET_I = 1'b0;
		chk(RELAY_O, 1'b0);
		acc(1'b0, 16'h02D6, 16'h0000, 1'b0, 16'h0000);
		acc(1'b0, 16'h02D8, 16'h0000, 1'b0, 16'h0000);
		acc(1'b0, 16'h02DC, 16'h0000, 1'b0, 16'h0014);
		end_sim();
	end
endmodule : field_input_run_control_bench
`default_nettype wire

// ==== testbench/firc_field_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module firc_field_model (
	input  wire logic       run_i,
	input  wire logic       perm_i,
	input  wire logic [1:0] aux_i,
	input  wire logic       bounce_i,
	output logic      [3:0] field_o
);
	// chatter inverts the run contact briefly
	assign field_o = {aux_i, perm_i, run_i ^ bounce_i};
endmodule : firc_field_model
`default_nettype wire

// ==== testbench/firc_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module firc_properties #(
	parameter int TICK_CYC = 10,
	parameter int N_IN     = 4
) (
	input wire logic            SYS_CLK_I,
	input wire logic            RESET_I,
	input wire logic [N_IN-1:0] FIELD_IN_I,
	input wire logic            POWER_LOSS_I,
	input wire logic [15:0]     REG_ADDR_I,
	input wire logic            REG_WR_I,
	input wire logic [15:0]     REG_WDATA_I,
	input wire logic            REG_ACK_O,
	input wire logic            REG_ERR_O,
	input wire logic            MOTOR_RUN_O,
	input wire logic            RELAY_O,
	input wire logic [N_IN-1:0] DEB_IN_O
);
	logic       mode;
	logic [1:0] act;
	int         stab;
	wire        wr_t = REG_WR_I && REG_ADDR_I >= 16'h02D9 && REG_ADDR_I <= 16'h02DC;
	// shadow of wiring mode and power-down action
	always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			mode <= 1'b0;
			act  <= 2'h0;
			stab <= 0;
		end else begin
			mode <= (REG_WR_I && REG_ADDR_I == 16'h02D8 && REG_WDATA_I < 16'h0002) ? REG_WDATA_I[0] : mode;
			act  <= (REG_WR_I && REG_ADDR_I == 16'h02D6 && REG_WDATA_I < 16'h0004) ? REG_WDATA_I[1:0] : act;
			stab <= $changed(FIELD_IN_I[0]) ? 0 : stab + 1;
		end
	end
	default clocking @(posedge SYS_CLK_I);
	endclocking
	default disable iff (RESET_I);
	sequence pl_rise_s;
		$rose(POWER_LOSS_I) ##1 POWER_LOSS_I [*7];
	endsequence
	time_range_a: assert property (wr_t && (REG_WDATA_I < 16'h0005 || REG_WDATA_I > 16'h1388)
		|=> REG_ERR_O && !REG_ACK_O) else $error("bad time taken");
	two_wire_a: assert property (!$past(mode) |-> MOTOR_RUN_O == $past(DEB_IN_O[0])) else $error("run wrong");
	no_permit_a: assert property ($past(mode) && !$past(DEB_IN_O[1]) |-> !MOTOR_RUN_O) else $error("run no permit");
	permit_drop_a: assert property (mode && $fell(DEB_IN_O[1]) |=> !MOTOR_RUN_O) else $error("no stop");
	pulse_hold_a: assert property (mode && MOTOR_RUN_O && DEB_IN_O[1] |=> MOTOR_RUN_O) else $error("run lost");
	debounce_a: assert property ($changed(DEB_IN_O[0]) |-> stab >= 4 * TICK_CYC) else $error("early level");
	pd_action_a: assert property (pl_rise_s |-> act[1] || RELAY_O == act[0]) else $error("relay action");
	pd_hold_a: assert property (pl_rise_s |=> $stable(RELAY_O)) else $error("relay moved");
endmodule : firc_properties
bind firc_top firc_properties #(.TICK_CYC(TICK_CYC), .N_IN(N_IN)) firc_properties_inst (.*);
`default_nettype wire
